// ==== verilog/lvd_pkg.sv ====
// supply monitor package: register map, field positions, decode values
// assumes a 250 MHz system clock and an AXI4-Lite register bus
package lvd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00; // supply_monitor_control
  localparam logic [7:0] FLAG_OFFSET = 8'h04; // undervoltage flag
  localparam logic [7:0] OSC_OFFSET  = 8'h08; // rc frequency select readback

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT   = 3;            // supply_monitor_enable
  localparam int NOT_LOW_BIT  = 2;            // live supply-good status
  localparam int FLAG_BIT     = 4;            // undervoltage_flag
  localparam logic [7:0] CTRL_RESET = 8'h00;  // control after reset
  localparam logic [1:0] RC_SEL_DEFAULT = 2'h3; // 4 MHz before strap

  // ----------------------------------------------------------------
  // trip levels and rc frequencies
  // ----------------------------------------------------------------
  localparam logic [1:0]  LEVEL_2V2 = 2'h3;
  localparam logic [1:0]  LEVEL_3V3 = 2'h2;
  localparam logic [1:0]  LEVEL_4V0 = 2'h1;
  localparam logic [1:0]  LEVEL_4V5 = 2'h0;
  localparam logic [12:0] TRIP_MV_2V2 = 13'd2200;
  localparam logic [12:0] TRIP_MV_3V3 = 13'd3300;
  localparam logic [12:0] TRIP_MV_4V0 = 13'd4000;
  localparam logic [12:0] TRIP_MV_4V5 = 13'd4500;
  localparam logic [1:0]  RC_4MHZ   = 2'h3;
  localparam logic [1:0]  RC_8MHZ   = 2'h2;
  localparam logic [1:0]  RC_1MHZ   = 2'h1;
  localparam logic [1:0]  RC_455KHZ = 2'h0;
  localparam logic [13:0] KHZ_4MHZ   = 14'd4000;
  localparam logic [13:0] KHZ_8MHZ   = 14'd8000;
  localparam logic [13:0] KHZ_1MHZ   = 14'd1000;
  localparam logic [13:0] KHZ_455KHZ = 14'd455;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 250;               // mclk_i rate
  localparam int DIP_TIME_US = 80;                // dip filter time
  localparam int DIP_CYCLES  = DIP_TIME_US * CLK_MHZ;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;     // cycles before capture

  // ----------------------------------------------------------------
  // bus answers and carriers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]  awaddr;   // write address
    logic        awvalid;  // write address valid
    logic [31:0] wdata;    // write data
    logic [3:0]  wstrb;    // byte strobes
    logic        wvalid;   // write data valid
    logic        bready;   // response ready
    logic [7:0]  araddr;   // read address
    logic        arvalid;  // read address valid
    logic        rready;   // read data ready
  } axil_req_s;

  typedef struct packed {
    logic        awready;  // write address ready
    logic        wready;   // write data ready
    logic        bvalid;   // response valid
    logic [1:0]  bresp;    // response code
    logic        arready;  // read address ready
    logic        rvalid;   // read data valid
    logic [31:0] rdata;    // read data
    logic [1:0]  rresp;    // read response code
  } axil_rsp_s;

endpackage

// ==== verilog/level_sync3.sv ====
// three-stage synchroniser for slow pin levels
// assumes inputs are quasi-static levels from outside the clock domain
`timescale 1ns/10ps
module level_sync3 #(
  parameter int WIDTH = 1                    // number of levels
) (
  input  wire logic             clk_i,       // system clock
  input  wire logic             rst_n_i,     // synchronised reset, low
  input  wire logic [WIDTH-1:0] async_i,     // raw pin levels
  output logic      [WIDTH-1:0] level_o      // agreed level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;   // metastability catcher
    logic [WIDTH-1:0] s2;   // second stage
    logic [WIDTH-1:0] s3;   // third stage
    logic [WIDTH-1:0] out;  // accepted level
  } sync_state_s;

  sync_state_s st;       // registered state
  sync_state_s next_st;  // next state

  // ----------------------------------------------------------------
  // accept a bit only when stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.out[i] = st.s3[i]; // RL14
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.out;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sync_agree: assert property ( // RL14
    $changed(level_o) |-> $past(st.s2 == st.s3))
    else $error("synchroniser output moved without agreement");

endmodule

// ==== verilog/dip_filter.sv ====
// supply dip duration filter: long dips below reset voltage ask for reset
// assumes a synchronised below-reset level on the system clock
`timescale 1ns/10ps
module dip_filter #(
  parameter int LIMIT = 20000                // cycles a dip may last
) (
  input  wire logic clk_i,                   // system clock
  input  wire logic rst_n_i,                 // synchronised reset, low
  input  wire logic below_i,                 // supply below reset_voltage
  output logic      reset_req_o              // system reset request
);

  localparam int CNT_W = $clog2(LIMIT + 1);  // counter width

  typedef struct packed {
    logic [CNT_W-1:0] count;  // cycles spent below
    logic             req;    // reset request
  } dip_state_s;

  dip_state_s st;       // registered state
  dip_state_s next_st;  // next state

  // ----------------------------------------------------------------
  // count the dip, request reset once it outlasts the limit
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (below_i) begin
      if (st.count < CNT_W'(LIMIT)) begin
        next_st.count = st.count + CNT_W'(1);
      end else begin
        next_st.req = 1'b1; // RL11
      end
    end else begin
      next_st.count = '0; // RL10
      next_st.req   = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reset_req_o = st.req;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_short_dip_ignored: assert property ( // RL10
    !below_i |=> (!reset_req_o && st.count == '0))
    else $error("dip end did not clear the filter");

  a_long_dip_reset: assert property ( // RL11
    (below_i && st.count == CNT_W'(LIMIT)) |=> reset_req_o)
    else $error("long dip gave no reset request");

  a_no_early_reset: assert property ( // RL10
    $rose(reset_req_o) |-> $past(st.count) == CNT_W'(LIMIT))
    else $error("reset request before dip limit");

endmodule

// ==== verilog/low_voltage_detect_monitor.sv ====
// low-voltage detect monitor: control and flag registers over AXI4-Lite,
// dip filter toward system reset, internal rc frequency select decode
// assumes analog comparators outside give below-level pins, the core
// gives its global interrupt enable on mclk_i, and a system reset
// drives resetn_i low
//
// Function
// (RL1) monitor runs only while enable bit set
// (RL2) two-bit field picks one of four trips
// (RL3) supply below trip sets undervoltage flag
// (RL4) flag stays zero while supply above trip
// (RL5) flag with global enable raises interrupt
// (RL6) only software write of zero clears flag; the code also clears it when the enable bit is cleared
// (RL7) any system reset clears the flag
// (RL8) monitor works in sleep, never wakes
// (RL9) flag set in sleep is retained
// (RL10) dips under 80 us are ignored
// (RL11) dips over 80 us force system reset
// (RL12) rc oscillator defaults 4 MHz, three alternatives
// (RL13) rc select codes 11,10,01,00 map 4,8,1,0.455
// (RL14) comparator synchronised, flag set from that
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module low_voltage_detect_monitor #(
  parameter int DIP_CYCLES = lvd_pkg::DIP_CYCLES  // dip limit in cycles
) (
  input  wire logic              mclk_i,          // system clock
  input  wire logic              resetn_i,        // system reset, low
  input  wire lvd_pkg::axil_req_s axil_i,         // bus requests
  output lvd_pkg::axil_rsp_s     axil_o,          // bus answers
  input  wire logic              below_trip_i,    // supply < trip_voltage
  input  wire logic              below_reset_i,   // supply < reset_voltage
  input  wire logic [1:0]        rc_freq_opt_i,   // rc select option bits
  input  wire logic              global_irq_en_i, // core interrupt enable
  output logic                   monitor_power_o, // analog monitor on
  output logic [1:0]             trip_level_o,    // trip level select
  output logic [12:0]            trip_mv_o,       // trip level in mV
  output logic                   irq_o,           // interrupt to core
  output logic                   reset_req_o,     // system reset request
  output logic [1:0]             irc_sel_o,       // rc frequency select
  output logic [13:0]            irc_khz_o        // rc frequency in kHz
);

  // ----------------------------------------------------------------
  // state and local signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_got;     // write address held
    logic [7:0]  awaddr;     // held write address
    logic        w_got;      // write data held
    logic [7:0]  wdata;      // held low byte of write data
    logic        wstrb0;     // held strobe of byte lane 0
    logic        awready;    // write address ready
    logic        wready;     // write data ready
    logic        bvalid;     // write response pending
    logic [1:0]  bresp;      // write response code
    logic        arready;    // read address ready
    logic        rvalid;     // read data pending
    logic [31:0] rdata;      // read data
    logic [1:0]  rresp;      // read response code
    logic        enable;     // supply_monitor_enable
    logic [1:0]  level;      // trip_level_select_hi/lo
    logic        flag;       // undervoltage_flag
    logic        irq;        // interrupt request
    logic [12:0] trip_mv;    // decoded trip voltage
    logic [2:0]  strap_cnt;  // settle count before strap capture
    logic        strap_done; // option bits captured
    logic [1:0]  rc_sel;     // rc_freq_select_hi/lo
    logic [13:0] khz;        // decoded rc frequency
  } mon_state_s;

  mon_state_s st;         // registered state
  mon_state_s next_st;    // next state
  logic [1:0] rst_sync;   // reset release synchroniser
  logic       rst_n;      // synchronised reset
  logic [3:0] synced;     // synchronised pin levels
  logic       below_trip; // synchronised trip comparator
  logic       below_rst;  // synchronised reset comparator
  logic [1:0] strap;      // synchronised option bits
  logic       wr_commit;  // write performed this cycle
  logic       wr_ctrl;    // control register written
  logic       wr_clear;   // flag cleared by software
  logic [7:0] rd_addr;    // aligned read address

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [12:0] trip_of(input logic [1:0] lvl);
    case (lvl)
      lvd_pkg::LEVEL_2V2: trip_of = lvd_pkg::TRIP_MV_2V2;
      lvd_pkg::LEVEL_3V3: trip_of = lvd_pkg::TRIP_MV_3V3;
      lvd_pkg::LEVEL_4V0: trip_of = lvd_pkg::TRIP_MV_4V0;
      default:            trip_of = lvd_pkg::TRIP_MV_4V5;
    endcase
  endfunction

  function automatic logic [13:0] khz_of(input logic [1:0] sel);
    case (sel)
      lvd_pkg::RC_4MHZ: khz_of = lvd_pkg::KHZ_4MHZ;
      lvd_pkg::RC_8MHZ: khz_of = lvd_pkg::KHZ_8MHZ;
      lvd_pkg::RC_1MHZ: khz_of = lvd_pkg::KHZ_1MHZ;
      default:          khz_of = lvd_pkg::KHZ_455KHZ;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // reset release synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // pin synchroniser and dip filter
  // ----------------------------------------------------------------
  level_sync3 #(
    .WIDTH   (4)
  ) u_sync (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .async_i ({rc_freq_opt_i, below_reset_i, below_trip_i}),
    .level_o (synced)
  );

  assign below_trip = synced[0];
  assign below_rst  = synced[1];
  assign strap      = synced[3:2];

  dip_filter #(
    .LIMIT       (DIP_CYCLES)
  ) u_dip (
    .clk_i       (mclk_i),
    .rst_n_i     (rst_n),
    .below_i     (below_rst),
    .reset_req_o (reset_req_o)
  );

  // ----------------------------------------------------------------
  // bus slave, flag and decode logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st   = st;
    wr_commit = 1'b0;
    wr_ctrl   = 1'b0;
    wr_clear  = 1'b0;
    rd_addr   = {axil_i.araddr[7:2], 2'h0};
    // write address and data are taken independently
    if (axil_i.awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = {axil_i.awaddr[7:2], 2'h0};
    end
    if (axil_i.wvalid && st.wready) begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = axil_i.wdata[7:0];
      next_st.wstrb0 = axil_i.wstrb[0];
    end
    // response taken by master
    if (axil_i.bready && st.bvalid) begin
      next_st.bvalid = 1'b0;
    end
    // both halves held: perform the write
    if (st.aw_got && st.w_got && !st.bvalid) begin
      wr_commit      = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = lvd_pkg::RESP_OKAY;
      case (st.awaddr)
        lvd_pkg::CTRL_OFFSET: wr_ctrl = st.wstrb0;
        lvd_pkg::FLAG_OFFSET: wr_clear = st.wstrb0 &&
                                !st.wdata[lvd_pkg::FLAG_BIT]; // RL6
        lvd_pkg::OSC_OFFSET:  wr_ctrl = 1'b0; // read-only, ignored
        default:              next_st.bresp = lvd_pkg::RESP_SLVERR;
      endcase
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;
    // control register write
    if (wr_ctrl) begin
      next_st.enable = st.wdata[lvd_pkg::ENABLE_BIT];
      next_st.level  = st.wdata[1:0];
    end
    // read channel
    if (axil_i.rready && st.rvalid) begin
      next_st.rvalid = 1'b0;
    end
    if (axil_i.arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 32'h0;
      next_st.rresp  = lvd_pkg::RESP_OKAY;
      case (rd_addr)
        lvd_pkg::CTRL_OFFSET: begin
          next_st.rdata[lvd_pkg::ENABLE_BIT]  = st.enable;
          next_st.rdata[lvd_pkg::NOT_LOW_BIT] = !(st.enable && below_trip);
          next_st.rdata[1:0]                  = st.level;
        end
        lvd_pkg::FLAG_OFFSET: begin
          next_st.rdata[lvd_pkg::FLAG_BIT] = st.flag;
        end
        lvd_pkg::OSC_OFFSET: begin
          next_st.rdata[1:0] = st.rc_sel;
        end
        default: begin
          next_st.rresp = lvd_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;
    // undervoltage flag: sticky, set beats software clear, disable beats set, sleep plays no part
    if (wr_clear) begin
      next_st.flag = 1'b0; // RL6
    end
    if (next_st.enable && below_trip) begin
      next_st.flag = 1'b1; // RL3 RL8 RL9 RL14
    end
    if (!next_st.enable) begin
      next_st.flag = 1'b0; // RL1 RL4
    end
    next_st.irq     = next_st.flag && global_irq_en_i; // RL5
    next_st.trip_mv = trip_of(next_st.level); // RL2
    // option bits are caught once the synchroniser has settled
    if (!st.strap_done) begin
      next_st.strap_cnt = st.strap_cnt + 3'h1;
      if (st.strap_cnt == lvd_pkg::STRAP_SETTLE) begin
        next_st.rc_sel     = strap; // RL12
        next_st.strap_done = 1'b1;
      end
    end
    next_st.khz = khz_of(next_st.rc_sel); // RL13
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0; // RL7
      st.enable  <= lvd_pkg::CTRL_RESET[lvd_pkg::ENABLE_BIT];
      st.level   <= lvd_pkg::CTRL_RESET[1:0];
      st.trip_mv <= lvd_pkg::TRIP_MV_4V5;
      st.rc_sel  <= lvd_pkg::RC_SEL_DEFAULT;
      st.khz     <= lvd_pkg::KHZ_4MHZ;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axil_o.awready = st.awready;
  assign axil_o.wready  = st.wready;
  assign axil_o.bvalid  = st.bvalid;
  assign axil_o.bresp   = st.bresp;
  assign axil_o.arready = st.arready;
  assign axil_o.rvalid  = st.rvalid;
  assign axil_o.rdata   = st.rdata;
  assign axil_o.rresp   = st.rresp;
  assign monitor_power_o = st.enable; // RL1
  assign trip_level_o    = st.level;
  assign trip_mv_o       = st.trip_mv;
  assign irq_o           = st.irq;
  assign irc_sel_o       = st.rc_sel;
  assign irc_khz_o       = st.khz;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  a_flag_held_off: assert property ( // RL1
    !st.enable |-> !st.flag)
    else $error("flag set while monitor disabled");

  a_trip_decode: assert property ( // RL2
    trip_mv_o == ((trip_level_o == 2'h3) ? 13'd2200 :
                  (trip_level_o == 2'h2) ? 13'd3300 :
                  (trip_level_o == 2'h1) ? 13'd4000 : 13'd4500))
    else $error("trip voltage decode wrong");

  a_flag_sets: assert property ( // RL3
    (st.enable && below_trip) |=> (st.flag || !st.enable))
    else $error("flag not set on low supply");

  a_flag_quiet: assert property ( // RL4
    $rose(st.flag) |-> $past(below_trip))
    else $error("flag rose without low supply");

  a_irq_follows: assert property ( // RL5
    (st.flag && global_irq_en_i) |=> (irq_o || !st.flag))
    else $error("flag with enable gave no interrupt");

  a_flag_sticky: assert property ( // RL6
    (st.flag && !wr_clear && next_st.enable) |=> st.flag)
    else $error("flag cleared without software write");

  a_rc_decode: assert property ( // RL13
    irc_khz_o == ((irc_sel_o == 2'h3) ? 14'd4000 :
                  (irc_sel_o == 2'h2) ? 14'd8000 :
                  (irc_sel_o == 2'h1) ? 14'd1000 : 14'd455))
    else $error("rc frequency decode wrong");

  a_write_answer: assert property ( // bus write response, our own choice
    wr_commit |=> (axil_o.bvalid && !axil_o.awready))
    else $error("write gave no response");

endmodule

// ==== verif/low_voltage_detect_monitor_tb.sv ====
// testbench for the low-voltage detect monitor: bus reads and writes,
// flag set and clear, dip filter and rc select decode
// assumes lvd_pkg is compiled first and a short dip limit of 20 cycles
`timescale 1ns/10ps
module low_voltage_detect_monitor_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               mclk_i;          // system clock
  logic               resetn_i;        // system reset, low
  lvd_pkg::axil_req_s req;             // bus requests
  lvd_pkg::axil_rsp_s rsp;             // bus answers
  logic               below_trip;      // comparator level
  logic               below_reset;     // reset comparator level
  logic [1:0]         rc_opt;          // rc strap bits
  logic               irq_en;          // core interrupt enable
  logic               mon_pwr;         // analog monitor power
  logic [1:0]         trip_lvl;        // trip level select
  logic [12:0]        trip_mv;         // trip level in mV
  logic               irq;             // interrupt to core
  logic               rst_req;         // system reset request
  logic [1:0]         irc_sel;         // rc select
  logic [13:0]        irc_khz;         // rc frequency in kHz
  int                 miscompares;     // mismatches seen
  int                 tests_run;       // comparisons made
  logic [31:0]        rd;              // read data
  logic [1:0]         rs;              // response code
  logic               seen;            // any reset request seen
  int                 mv[4]  = '{4500, 4000, 3300, 2200}; // per trip code
  int                 khz[4] = '{455, 1000, 8000, 4000};  // per rc code

  low_voltage_detect_monitor #(.DIP_CYCLES(20)) i_low_voltage_detect_monitor (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .axil_i(req), .axil_o(rsp),
    .below_trip_i(below_trip), .below_reset_i(below_reset),
    .rc_freq_opt_i(rc_opt), .global_irq_en_i(irq_en),
    .monitor_power_o(mon_pwr), .trip_level_o(trip_lvl), .trip_mv_o(trip_mv),
    .irq_o(irq), .reset_req_o(rst_req), .irc_sel_o(irc_sel),
    .irc_khz_o(irc_khz));

  // clock toggles every half period of 2 ns
  always #2 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // compare one value and count it
  task automatic chk(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // bus write: address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk_i);
      if (!aw_ok && rsp.awready) begin
        aw_ok = 1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready) begin
        w_ok = 1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge mclk_i); while (rsp.bvalid !== 1'b1);
    rs = rsp.bresp;
    req.bready <= 1'b0;
    // let an edge pass so a following call never re-raises bready at once
    @(posedge mclk_i);
  endtask

  // bus read: result left in rd and rs
  task automatic rdr(input logic [7:0] a);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do @(posedge mclk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge mclk_i); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    // let an edge pass so a following call never re-raises rready at once
    @(posedge mclk_i);
  endtask

  // system reset with a given rc strap, then let pins settle
  task automatic do_reset(input logic [1:0] code);
    rc_opt <= code;
    resetn_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
  endtask

  // counts, verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 0;
    resetn_i = 0;
    req = '0;
    below_trip = 0;
    below_reset = 0;
    rc_opt = 2'h3;
    irq_en = 0;
    miscompares = 0;
    tests_run = 0;
    do_reset(2'h3);
    chk(32'(irc_khz), 32'd4000, "rc default");
    rdr(lvd_pkg::CTRL_OFFSET);
    chk(rd, 32'h04, "ctrl reset");
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h00, "flag reset");
    rdr(8'h0c);
    chk(32'(rs), 32'(lvd_pkg::RESP_SLVERR), "unmapped read");
    wr(8'h0c, 32'h0);
    chk(32'(rs), 32'(lvd_pkg::RESP_SLVERR), "unmapped write");
    wr(lvd_pkg::OSC_OFFSET, 32'h0);
    chk(32'(rs), 32'(lvd_pkg::RESP_OKAY), "read-only write");
    rdr(lvd_pkg::OSC_OFFSET);
    chk(rd, 32'h3, "rc select kept");
    $display("test reset_values done");
    // every trip code with the monitor on
    for (int i = 0; i < 4; i++) begin
      wr(lvd_pkg::CTRL_OFFSET, 32'h08 | i);
      repeat (2) @(posedge mclk_i);
      chk(32'(trip_mv), mv[i], "trip mv");
      chk(32'(trip_lvl), i, "trip level");
      chk(32'(mon_pwr), 32'd1, "monitor on");
    end
    $display("test trip_levels done");
    wr(lvd_pkg::CTRL_OFFSET, 32'h09);
    below_trip <= 1'b1;
    irq_en <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk(32'(irq), 32'd1, "irq raised");
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h10, "flag set");
    rdr(lvd_pkg::CTRL_OFFSET);
    chk(rd, 32'h09, "supply low status");
    below_trip <= 1'b0;
    irq_en <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk(32'(irq), 32'd0, "irq masked");
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h10, "flag held");
    wr(lvd_pkg::FLAG_OFFSET, 32'h10);
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h10, "write one keeps");
    wr(lvd_pkg::FLAG_OFFSET, 32'h00);
    repeat (8) @(posedge mclk_i);
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h00, "cleared, supply good");
    $display("test flag done");
    below_trip <= 1'b1;
    wr(lvd_pkg::CTRL_OFFSET, 32'h01);
    repeat (8) @(posedge mclk_i);
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h00, "disabled flag");
    chk(32'(mon_pwr), 32'd0, "monitor off");
    wr(lvd_pkg::CTRL_OFFSET, 32'h08);
    repeat (8) @(posedge mclk_i);
    below_trip <= 1'b0;
    do_reset(2'h3);
    rdr(lvd_pkg::FLAG_OFFSET);
    chk(rd, 32'h00, "flag after reset");
    $display("test disable_reset done");
    // a short dip is ignored, a long one asks for reset
    seen = 0;
    // a dip of exactly the limit is still ignored
    below_reset <= 1'b1;
    repeat (20) @(posedge mclk_i);
    below_reset <= 1'b0;
    repeat (20) begin
      @(posedge mclk_i);
      seen = seen | rst_req;
    end
    chk(32'(seen), 32'd0, "short dip");
    // one cycle over the limit asks for reset
    seen = 0;
    below_reset <= 1'b1;
    repeat (21) @(posedge mclk_i);
    below_reset <= 1'b0;
    repeat (20) begin
      @(posedge mclk_i);
      seen = seen | rst_req;
    end
    chk(32'(seen), 32'd1, "dip just over");
    below_reset <= 1'b1;
    repeat (40) @(posedge mclk_i);
    chk(32'(rst_req), 32'd1, "long dip");
    below_reset <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk(32'(rst_req), 32'd0, "dip over");
    $display("test dip done");
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0]);
      chk(32'(irc_khz), khz[i], "rc khz");
      chk(32'(irc_sel), i, "rc select");
      rdr(lvd_pkg::OSC_OFFSET);
      chk(rd, i, "rc readback");
    end
    $display("test rc_select done");
    wrap_up();
  end

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
